// >>> inc/cpu_regs_consts.svh
`ifndef CPU_REGS_CONSTS_SVH
`define CPU_REGS_CONSTS_SVH
`define ADDR_PROGRAM_COUNTER 4'h0
`define ADDR_MAIN_ACC 4'h1
`define ADDR_TEMP_ACC 4'h2
`define ADDR_INDEX_REG 4'h3
`define ADDR_EXTRA_PTR 4'h4
`define ADDR_STACK_PTR 4'h5
`define ADDR_STATUS_WORD 4'h6
`define ADDR_ALU_CTRL 4'h7
`define ADDR_BANK_BASE 4'h8
`define ADDR_IRQ_CTRL 4'h9
`define RESET_WORD 16'h0000
`define RESET_CCR 8'h00
`define RESET_BANK_PTR 8'h00
`define CCR_CARRY 0
`define CCR_OVERFLOW 1
`define CCR_ZERO 2
`define CCR_NEGATIVE 3
`define CCR_IL_LO 4
`define CCR_IL_HI 5
`define CCR_IRQ_EN 6
`define CCR_HALF 7
`define IL_NONE 2'h3
`define RAM_DATA_BASE 16'h0100
`endif

// >>> inc/cpu_regs_pkg.sv
package cpu_regs_pkg;
  typedef enum logic [2:0] {
    OP_ADD,
    OP_SUB,
    OP_SHL,
    OP_SHR,
    OP_NONE
  } alu_op_type;
  typedef struct packed {
    logic [7:0] bank_pointer;
    logic [7:0] condition_code_byte;
  } status_word_type;
endpackage : cpu_regs_pkg

// >>> rtl/cpu_register_set_flags.sv
`timescale 1ns/10ps
`include "cpu_regs_consts.svh"
module cpu_register_set_flags #(
  parameter int BANK_COUNT = 32
) (
  input wire logic CLK,
  input wire logic RESETN,
  input wire logic [3:0] ADDR,
  input wire logic [15:0] WDATA,
  input wire logic WR,
  input wire logic RD,
  output logic [15:0] RDATA,
  input wire logic [1:0] IRQ_LEVEL,
  input wire logic IRQ_REQ,
  output logic IRQ_ADMIT,
  input wire logic [2:0] GPR_INDEX,
  output logic [15:0] GPR_ADDR,
  output logic GPR_BANK_VALID
);

  // Only the two RAM sizes of the family are served
  if (BANK_COUNT != 16 && BANK_COUNT != 32) begin : g_bank_count_check
    $error("BANK_COUNT must be 16 or 32");
  end

  // The level field must be two adjacent flag bits
  if (`CCR_IL_HI != `CCR_IL_LO + 1) begin : g_level_field_check
    $error("level field bits must be adjacent");
  end

  // A bank base is only found by concatenation when the data area is 8-aligned
  if ((`RAM_DATA_BASE & 16'h0007) != 16'h0000) begin : g_ram_base_check
    $error("RAM data base must be aligned to a bank");
  end

  // Dedicated registers, each beside its next value
  logic [15:0] program_counter_r;
  logic [15:0] program_counter_nxt;
  logic [15:0] main_acc_r;
  logic [15:0] main_acc_nxt;
  logic [15:0] temp_acc_r;
  logic [15:0] temp_acc_nxt;
  logic [15:0] index_register_r;
  logic [15:0] index_register_nxt;
  logic [15:0] extra_pointer_r;
  logic [15:0] extra_pointer_nxt;
  logic [15:0] stack_pointer_r;
  logic [15:0] stack_pointer_nxt;

  // Status word halves are kept apart so each has one writer
  logic [7:0] bank_pointer_r;
  logic [7:0] bank_pointer_nxt;
  logic [7:0] ccr_r;
  logic [7:0] ccr_alu;
  logic [7:0] ccr_nxt;
  cpu_regs_pkg::status_word_type status_word;

  // Arithmetic paths on the low accumulator bytes
  cpu_regs_pkg::alu_op_type op_nxt;
  logic [8:0] add9;
  logic [4:0] add5;
  logic [8:0] sub9;
  logic [4:0] sub5;
  logic [7:0] shl8;
  logic shl_out;
  logic [7:0] shr8;
  logic shr_out;
  logic [7:0] res8;

  // Register bus
  logic pc_hit;
  logic main_acc_hit;
  logic temp_acc_hit;
  logic index_hit;
  logic extra_hit;
  logic stack_hit;
  logic status_hit;
  logic alu_hit;
  logic irq_hit;
  logic [15:0] rdata_nxt;
  logic [15:0] rdata_r;

  // Interrupt gate and bank addressing
  logic irq_enable;
  logic [1:0] irq_field;
  logic [15:0] bank_base_addr;

  // A write strobe hits one register when its address matches
  function automatic logic write_hit(input logic wr_strobe, input logic [3:0] a, input logic [3:0] sel);
    write_hit = wr_strobe && (a == sel);
  endfunction : write_hit

  // Bank number sits above the three-bit register index in the data area
  function automatic logic [15:0] bank_base(input logic [7:0] bank_ptr);
    bank_base = `RAM_DATA_BASE + {5'h00, bank_ptr[4:0], 3'h0};
  endfunction : bank_base

  // Two's-complement overflow of an 8-bit add or subtract
  function automatic logic overflow8(input logic op_a7, input logic op_b7, input logic res7, input logic is_sub);
    overflow8 = ((op_a7 ^ op_b7) == is_sub) && (res7 != op_a7);
  endfunction : overflow8

  // Lower level number means higher priority; field 11 shuts all out
  function automatic logic level_admits(input logic [1:0] level, input logic [1:0] field);
    level_admits = (field != `IL_NONE) && (level < field);
  endfunction : level_admits

  // Decode: one strobe and one address pick one register
  assign pc_hit = write_hit(WR, ADDR, `ADDR_PROGRAM_COUNTER);
  assign main_acc_hit = write_hit(WR, ADDR, `ADDR_MAIN_ACC);
  assign temp_acc_hit = write_hit(WR, ADDR, `ADDR_TEMP_ACC);
  assign index_hit = write_hit(WR, ADDR, `ADDR_INDEX_REG);
  assign extra_hit = write_hit(WR, ADDR, `ADDR_EXTRA_PTR);
  assign stack_hit = write_hit(WR, ADDR, `ADDR_STACK_PTR);
  assign status_hit = write_hit(WR, ADDR, `ADDR_STATUS_WORD);
  assign alu_hit = write_hit(WR, ADDR, `ADDR_ALU_CTRL);
  assign irq_hit = write_hit(WR, ADDR, `ADDR_IRQ_CTRL);

  // Plain registers take the bus word or hold
  assign program_counter_nxt = pc_hit ? WDATA : program_counter_r;
  assign temp_acc_nxt = temp_acc_hit ? WDATA : temp_acc_r;
  assign index_register_nxt = index_hit ? WDATA : index_register_r;
  assign extra_pointer_nxt = extra_hit ? WDATA : extra_pointer_r;
  assign stack_pointer_nxt = stack_hit ? WDATA : stack_pointer_r;
  // Bank pointer changes only by a whole status word write
  assign bank_pointer_nxt = status_hit ? WDATA[15:8] : bank_pointer_r;

  // Operation write: 8-bit op on low bytes of main and temp accumulators
  always_comb begin
    op_nxt = cpu_regs_pkg::OP_NONE;
    if (alu_hit) begin
      unique case (WDATA[1:0])
        2'h0: begin
          op_nxt = cpu_regs_pkg::OP_ADD;
        end
        2'h1: begin
          op_nxt = cpu_regs_pkg::OP_SUB;
        end
        2'h2: begin
          op_nxt = cpu_regs_pkg::OP_SHL;
        end
        2'h3: begin
          op_nxt = cpu_regs_pkg::OP_SHR;
        end
      endcase
    end
  end

  // Adder: carries out of bit 7 and bit 3
  always_comb begin
    add9 = {1'b0, main_acc_r[7:0]} + {1'b0, temp_acc_r[7:0]};
    add5 = {1'b0, main_acc_r[3:0]} + {1'b0, temp_acc_r[3:0]};
  end

  // Subtractor: bit 8 and bit 4 read as borrows
  always_comb begin
    sub9 = {1'b0, main_acc_r[7:0]} - {1'b0, temp_acc_r[7:0]};
    sub5 = {1'b0, main_acc_r[3:0]} - {1'b0, temp_acc_r[3:0]};
  end

  // Shifters keep the bit that falls off for the carry
  always_comb begin
    shl8 = {main_acc_r[6:0], 1'b0};
    shl_out = main_acc_r[7];
    shr8 = {1'b0, main_acc_r[7:1]};
    shr_out = main_acc_r[0];
  end

  // Select: shifts leave half and overflow as they were
  always_comb begin
    ccr_alu = ccr_r;
    res8 = main_acc_r[7:0];
    unique case (op_nxt)
      cpu_regs_pkg::OP_ADD: begin
        res8 = add9[7:0];
        ccr_alu[`CCR_CARRY] = add9[8];
        ccr_alu[`CCR_HALF] = add5[4];
        ccr_alu[`CCR_OVERFLOW] = overflow8(main_acc_r[7], temp_acc_r[7], add9[7], 1'b0);
      end
      cpu_regs_pkg::OP_SUB: begin
        res8 = sub9[7:0];
        ccr_alu[`CCR_CARRY] = sub9[8];
        ccr_alu[`CCR_HALF] = sub5[4];
        ccr_alu[`CCR_OVERFLOW] = overflow8(main_acc_r[7], temp_acc_r[7], sub9[7], 1'b1);
      end
      cpu_regs_pkg::OP_SHL: begin
        res8 = shl8;
        ccr_alu[`CCR_CARRY] = shl_out;
      end
      cpu_regs_pkg::OP_SHR: begin
        res8 = shr8;
        ccr_alu[`CCR_CARRY] = shr_out;
      end
      cpu_regs_pkg::OP_NONE: begin
      end
    endcase
    if (op_nxt != cpu_regs_pkg::OP_NONE) begin
      ccr_alu[`CCR_NEGATIVE] = res8[7];
      ccr_alu[`CCR_ZERO] = (res8 == 8'h00);
    end
  end

  // Software writes win over the flag update; the two never share a cycle
  always_comb begin
    ccr_nxt = ccr_alu;
    if (status_hit) begin
      ccr_nxt = WDATA[7:0];
    end else if (irq_hit) begin
      ccr_nxt = ccr_r;
      ccr_nxt[`CCR_IRQ_EN] = WDATA[2];
      ccr_nxt[`CCR_IL_HI:`CCR_IL_LO] = WDATA[1:0];
    end
  end

  // Upper accumulator byte is kept by 8-bit operations
  always_comb begin
    main_acc_nxt = main_acc_r;
    if (op_nxt != cpu_regs_pkg::OP_NONE) begin
      main_acc_nxt = {main_acc_r[15:8], res8};
    end else if (main_acc_hit) begin
      main_acc_nxt = WDATA;
    end
  end

  // Program counter
  always_ff @(posedge CLK or negedge RESETN) begin
    if (!RESETN) begin
      program_counter_r <= `RESET_WORD;
    end else begin
      program_counter_r <= program_counter_nxt;
    end
  end

  // Main accumulator
  always_ff @(posedge CLK or negedge RESETN) begin
    if (!RESETN) begin
      main_acc_r <= `RESET_WORD;
    end else begin
      main_acc_r <= main_acc_nxt;
    end
  end

  // Temporary accumulator, the second operand
  always_ff @(posedge CLK or negedge RESETN) begin
    if (!RESETN) begin
      temp_acc_r <= `RESET_WORD;
    end else begin
      temp_acc_r <= temp_acc_nxt;
    end
  end

  // Index register
  always_ff @(posedge CLK or negedge RESETN) begin
    if (!RESETN) begin
      index_register_r <= `RESET_WORD;
    end else begin
      index_register_r <= index_register_nxt;
    end
  end

  // Extra pointer
  always_ff @(posedge CLK or negedge RESETN) begin
    if (!RESETN) begin
      extra_pointer_r <= `RESET_WORD;
    end else begin
      extra_pointer_r <= extra_pointer_nxt;
    end
  end

  // Stack pointer
  always_ff @(posedge CLK or negedge RESETN) begin
    if (!RESETN) begin
      stack_pointer_r <= `RESET_WORD;
    end else begin
      stack_pointer_r <= stack_pointer_nxt;
    end
  end

  // Bank pointer, upper half of the status word
  always_ff @(posedge CLK or negedge RESETN) begin
    if (!RESETN) begin
      bank_pointer_r <= `RESET_BANK_PTR;
    end else begin
      bank_pointer_r <= bank_pointer_nxt;
    end
  end

  // Condition code byte; reset leaves interrupts shut
  always_ff @(posedge CLK or negedge RESETN) begin
    if (!RESETN) begin
      ccr_r <= `RESET_CCR;
    end else begin
      ccr_r <= ccr_nxt;
    end
  end

  // Whole status word as software sees it
  assign status_word.bank_pointer = bank_pointer_r;
  assign status_word.condition_code_byte = ccr_r;

  // Enable and level field live in the flag byte
  assign irq_enable = ccr_r[`CCR_IRQ_EN];
  assign irq_field = ccr_r[`CCR_IL_HI:`CCR_IL_LO];
  assign IRQ_ADMIT = IRQ_REQ && irq_enable && level_admits(IRQ_LEVEL, irq_field);

  // Only five pointer bits reach the address; validity looks at all eight
  assign bank_base_addr = bank_base(bank_pointer_r);
  assign GPR_ADDR = bank_base_addr + {13'h0000, GPR_INDEX};
  assign GPR_BANK_VALID = ({24'h000000, bank_pointer_r} < BANK_COUNT);

  // Read select; write-only and unmapped addresses read as zero
  always_comb begin
    rdata_nxt = 16'h0000;
    if (RD) begin
      unique case (ADDR)
        `ADDR_PROGRAM_COUNTER: begin
          rdata_nxt = program_counter_r;
        end
        `ADDR_MAIN_ACC: begin
          rdata_nxt = main_acc_r;
        end
        `ADDR_TEMP_ACC: begin
          rdata_nxt = temp_acc_r;
        end
        `ADDR_INDEX_REG: begin
          rdata_nxt = index_register_r;
        end
        `ADDR_EXTRA_PTR: begin
          rdata_nxt = extra_pointer_r;
        end
        `ADDR_STACK_PTR: begin
          rdata_nxt = stack_pointer_r;
        end
        `ADDR_STATUS_WORD: begin
          rdata_nxt = status_word;
        end
        `ADDR_BANK_BASE: begin
          rdata_nxt = bank_base_addr;
        end
        default: begin
          rdata_nxt = 16'h0000;
        end
      endcase
    end
  end

  // Read data stand for one cycle only, zero otherwise
  always_ff @(posedge CLK or negedge RESETN) begin
    if (!RESETN) begin
      rdata_r <= 16'h0000;
    end else begin
      rdata_r <= rdata_nxt;
    end
  end

  assign RDATA = rdata_r;
endmodule : cpu_register_set_flags

// >>> verification/cpu_regs_chk.sv
`timescale 1ns/10ps
module cpu_regs_chk #(
  parameter int BANK_COUNT = 32
) (
  input wire logic CLK,
  input wire logic RESETN,
  input wire logic [3:0] ADDR,
  input wire logic [15:0] WDATA,
  input wire logic WR,
  input wire logic RD,
  input wire logic [15:0] RDATA,
  input wire logic [1:0] IRQ_LEVEL,
  input wire logic IRQ_REQ,
  input wire logic IRQ_ADMIT,
  input wire logic [2:0] GPR_INDEX,
  input wire logic [15:0] GPR_ADDR,
  input wire logic GPR_BANK_VALID
);
  default clocking cb @(posedge CLK);
  endclocking
  default disable iff (!RESETN);
  word_back_a: assert property ((WR && ADDR < 4'h7) ##1 (RD && ADDR == $past(ADDR))
    |=> RDATA == $past(WDATA, 2)) else $error("register readback differs");
  reset_mask_a: assert property (!$past(RESETN) |-> !IRQ_ADMIT) else $error("admit right after reset");
  admit_cause_a: assert property (IRQ_ADMIT |-> IRQ_REQ && IRQ_LEVEL != 2'h3) else $error("admit without cause");
  irq_off_a: assert property (WR && ADDR == 4'h9 && !WDATA[2] |=> !IRQ_ADMIT) else $error("admit while off");
  irq_on_a: assert property ((WR && ADDR == 4'h9 && WDATA[2] && WDATA[1:0] != 2'h3) ##1
    (IRQ_REQ && IRQ_LEVEL < $past(WDATA[1:0]))
    |-> IRQ_ADMIT) else $error("higher level not admitted");
  bank_addr_a: assert property (WR && ADDR == 4'h6 |=>
    GPR_ADDR == 16'h0100 + {8'h0, $past(WDATA[12:8]), 3'h0} + 16'(GPR_INDEX)) else $error("bank address wrong");
  bank_ok_a: assert property (WR && ADDR == 4'h6 |=> GPR_BANK_VALID == ($past(WDATA[15:8]) < BANK_COUNT))
    else $error("bank valid wrong");
  write_only_a: assert property (RD && ADDR > 4'h8 |=> RDATA == 16'h0) else $error("write-only read not zero");
endmodule : cpu_regs_chk

// >>> verification/tb.sv
`timescale 1ns/10ps
module tb;
  localparam int BANK_COUNT = 16;
  logic CLK = 0, RESETN = 0, WR = 0, RD = 0, IRQ_REQ = 0, rd_p = 0, IRQ_ADMIT, GPR_BANK_VALID;
  logic [3:0] ADDR = 0;
  logic [15:0] WDATA = 0, RDATA, GPR_ADDR, a, t, q[$];
  logic [1:0] IRQ_LEVEL = 0;
  logic [2:0] GPR_INDEX = 0;
  logic [31:0] seed = 32'hda33280a;
  logic [8:0] s;
  logic h, v;
  int n_mismatch = 0, comparisons = 0;
  cpu_register_set_flags #(.BANK_COUNT(BANK_COUNT)) u_dut (.*);
  always #12.5 CLK = ~CLK;
  function automatic logic [31:0] xs();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction : xs
  task automatic chk(string n, logic [15:0] e, logic [15:0] x);
    comparisons++;
    if (x !== e) begin
      n_mismatch++;
      $display("MISMATCH %s expected %h seen %h", n, e, x);
    end
  endtask : chk
  task automatic results();
    $display("comparisons %0d mismatches %0d", comparisons, n_mismatch);
    if (n_mismatch == 0 && comparisons > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask : results
  // Strobes are raised here and in rd(), each dropping the other's; st() drops both, so no signal is assigned twice per step
  task automatic wr(logic [3:0] ad, logic [15:0] d);
    @(posedge CLK);
    ADDR <= ad;
    WDATA <= d;
    WR <= 1;
    RD <= 0;
  endtask : wr
  task automatic rd(logic [3:0] ad, logic [15:0] e);
    @(posedge CLK);
    q.push_back(e);
    ADDR <= ad;
    RD <= 1;
    WR <= 0;
  endtask : rd
  task automatic st(logic r, logic [1:0] l);
    @(posedge CLK);
    WR <= 0;
    RD <= 0;
    IRQ_REQ <= r;
    IRQ_LEVEL <= l;
    GPR_INDEX <= 3'(xs());
    #1;
  endtask : st
  always @(posedge CLK) rd_p <= RD;
  always @(negedge CLK) if (rd_p) chk("rdata", q.pop_front(), RDATA);
  initial begin
    #100000;
    n_mismatch++;
    results();
  end
  initial begin
    repeat (8) @(posedge CLK);
    RESETN <= 1;
    for (int i = 0; i < 7; i++) rd(4'(i), 16'h0);
    for (int i = 0; i < 7; i++) begin
      a = 16'(xs());
      wr(4'(i), a);
      rd(4'(i), a);
    end
    for (int i = 7; i < 16; i++) rd(4'(i), i == 8 ? 16'h0100 + {8'h0, a[12:8], 3'h0} : 16'h0);
    $display("test registers done");
    // Status cleared first so that the flags a shift keeps are known to be zero
    for (int i = 0; i < 16; i++) begin
      a = i == 0 ? 16'h0080 : 16'(xs());
      t = i == 0 ? 16'h0080 : 16'(xs());
      case (i % 4)
        0: s = a[7:0] + t[7:0];
        1: s = {1'b0, a[7:0]} - {1'b0, t[7:0]};
        2: s = {a[7:0], 1'b0};
        default: s = {a[0], 1'b0, a[7:1]};
      endcase
      h = i % 4 == 0 ? ({1'b0, a[3:0]} + t[3:0]) > 5'hf : i % 4 == 1 && a[3:0] < t[3:0];
      v = i % 4 < 2 && (a[7] ^ t[7]) == (i % 4 == 1) && s[7] != a[7];
      wr(4'h6, 16'h0);
      wr(4'h1, a);
      wr(4'h2, t);
      wr(4'h7, 16'(i % 4));
      rd(4'h6, {8'h0, h, 3'h0, s[7], s[7:0] == 8'h0, v, s[8]});
      rd(4'h1, {a[15:8], s[7:0]});
    end
    $display("test flags done");
    for (int b = 0; b < 32; b++) begin
      wr(4'h6, {8'(b), 8'h0});
      st(0, 0);
      chk("gpr_addr", 16'h0100 + {8'h0, 5'(b), GPR_INDEX}, GPR_ADDR);
      chk("bank_valid", 16'(b < BANK_COUNT), 16'(GPR_BANK_VALID));
    end
    $display("test banks done");
    for (int c = 0; c < 8; c++) begin
      wr(4'h9, 16'(c));
      for (int l = 0; l < 4; l++) begin
        h = xs() % 2 == 0;
        st(h, 2'(l));
        chk("irq_admit", 16'(h && c >= 4 && l < c % 4 && c % 4 != 3), 16'(IRQ_ADMIT));
      end
    end
    $display("test interrupts done");
    st(0, 0);
    st(0, 0);
    results();
  end
endmodule : tb
bind cpu_register_set_flags cpu_regs_chk #(.BANK_COUNT(BANK_COUNT)) u_chk (.*);
